// ===== rtl/onwd_consts.vh
// Constants for the OTP nibble write decoder
`ifndef ONWD_CONSTS_VH
`define ONWD_CONSTS_VH
// Index of each mirror byte
`define ONWD_BYTE_CFG1      4'h0
`define ONWD_BYTE_CFG2      4'h1
`define ONWD_BYTE_TYPE      4'h2
`define ONWD_BYTE_UD1       4'h3
// Bank select codes
`define ONWD_BANK0          2'h0
`define ONWD_BANK1          2'h1
`define ONWD_BANK2          2'h2
`define ONWD_BANK3          2'h3
// Nibble locations
`define ONWD_LOC_FIRST_USED 4'h6
`define ONWD_LOC_AUX        4'h6
`define ONWD_LOC_CFG2       4'h7
`define ONWD_LOC_TYPE       4'h8
`define ONWD_LOC_DEVICE_ID_SELECT      4'hA
`define ONWD_LOC_UD_FIRST   4'h8
`define ONWD_LOC_UD_LO_LAST 4'hE
`define ONWD_LOC_UD_HI_LAST 4'hF
// Bit masks of each target field inside its byte
`define ONWD_MASK_LOCK      8'h80
`define ONWD_MASK_TOS       8'h20
`define ONWD_MASK_ADDR      8'h0F
`define ONWD_MASK_FILTER    8'hC0
`define ONWD_MASK_DEVICE_ID_SELECT     8'h80
`define ONWD_MASK_AUX       8'h03
`define ONWD_MASK_LO        8'h0F
`define ONWD_MASK_HI        8'hF0
// Global address and response fields
`define ONWD_GLOBAL_ADDR    4'h0
`define ONWD_RESP_ZERO      4'h0
`define ONWD_RESP_ONES      4'hF
`define ONWD_RESP_MARK      2'h3
// Mirror reset values
`define ONWD_RST_CFG1       8'h00
`define ONWD_RST_CFG2       8'h01
`define ONWD_RST_TYPE       8'h00
`define ONWD_RST_UDATA      8'h00
`endif

// ===== rtl/onwd_udata_mem.v
// User data byte store with bit-masked write and registered read
`include "onwd_consts.vh"
module onwd_udata_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk_in,
  input  wire             rst_in,
  input  wire             wr_en_in,
  input  wire [AW-1:0]    wr_addr_in,
  input  wire [WIDTH-1:0] wr_mask_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             rd_en_in,
  input  wire [AW-1:0]    rd_addr_in,
  output reg  [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer         i;

  // Unmasked bits keep their stored value
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= `ONWD_RST_UDATA;
      end
      rd_data_out <= `ONWD_RST_UDATA;
    end else begin
      if (wr_en_in) begin
        mem[wr_addr_in] <= (mem[wr_addr_in] & ~wr_mask_in) |
                           (wr_data_in & wr_mask_in);
      end
      if (rd_en_in) begin
        rd_data_out <= mem[rd_addr_in];
      end
    end
  end
endmodule // onwd_udata_mem

// ===== rtl/onwd_decoder.v
// Write-nibble command decoder routing data into mirror and OTP fields
`include "onwd_consts.vh"
// What this block does
// - Unused locations program nothing and answer with the node address.
// - Bank 0 location 7: data bit 3 goes to user lock, config2 bit 7.
// - Bank 0 location 8: data bits 3:2 go to filter selection bits 7:6.
// - Bank 0 location 10: data bit 3 goes to device id select bit.
// - Bank 1 location 6: data bits 1:0 go to auxiliary config field.
// - Bank 1 location 7: all four data bits become the node address.
// - Bank 1 locations 8 to 14: nibble to low half of user bytes 1-7.
// - Bank 2 location 7: data bit 1 goes to test output select bit 5.
// - Bank 2 locations 8 to 15: nibble to high half of user bytes 1-8.
// - Program enable clear: update mirror only, answer with (new) address.
// - Program enable set: program OTP, answer location, bank, new contents.
// - Ignore commands to global address or in non-long formats.
module onwd_decoder (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        cmd_valid_in,
  input  wire        cmd_long_format_in,
  input  wire [3:0]  cmd_addr_in,
  input  wire [3:0]  nibble_location_in,
  input  wire [3:0]  cmd_data_in,
  input  wire [1:0]  bank_in,
  input  wire        program_enable_in,
  output reg         resp_valid_out,
  output reg  [15:0] resp_data_out,
  output reg         otp_program_out,
  output reg  [3:0]  otp_byte_out,
  output reg  [7:0]  otp_mask_out,
  output reg  [7:0]  otp_data_out,
  output wire [3:0]  node_address_out,
  output wire        user_lock_out,
  output wire        test_output_select_out,
  output wire [1:0]  filter_selection_out,
  output wire        device_id_select_out,
  output wire [1:0]  auxiliary_config_field_out
);
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_WRITE = 4'h2;
  localparam [3:0] ST_READ  = 4'h4;
  localparam [3:0] ST_RESP  = 4'h8;

  // Returns {used, byte index, field mask}
  function [12:0] onwd_target;
    input [1:0] bank;
    input [3:0] loc;
    reg   [3:0] ofs;
    begin
      ofs = loc - `ONWD_LOC_UD_FIRST;
      onwd_target = 13'h0000;
      if (loc < `ONWD_LOC_FIRST_USED) begin
        onwd_target = 13'h0000;
      end else if (bank == `ONWD_BANK0) begin
        if (loc == `ONWD_LOC_CFG2) begin
          onwd_target = {1'b1, `ONWD_BYTE_CFG2, `ONWD_MASK_LOCK};
        end else if (loc == `ONWD_LOC_TYPE) begin
          onwd_target = {1'b1, `ONWD_BYTE_TYPE, `ONWD_MASK_FILTER};
        end else if (loc == `ONWD_LOC_DEVICE_ID_SELECT) begin
          onwd_target = {1'b1, `ONWD_BYTE_CFG1, `ONWD_MASK_DEVICE_ID_SELECT};
        end
      end else if (bank == `ONWD_BANK1) begin
        if (loc == `ONWD_LOC_AUX) begin
          onwd_target = {1'b1, `ONWD_BYTE_CFG1, `ONWD_MASK_AUX};
        end else if (loc == `ONWD_LOC_CFG2) begin
          onwd_target = {1'b1, `ONWD_BYTE_CFG2, `ONWD_MASK_ADDR};
        end else if (loc >= `ONWD_LOC_UD_FIRST &&
                     loc <= `ONWD_LOC_UD_LO_LAST) begin
          onwd_target = {1'b1, `ONWD_BYTE_UD1 + ofs, `ONWD_MASK_LO};
        end
      end else if (bank == `ONWD_BANK2) begin
        if (loc == `ONWD_LOC_CFG2) begin
          onwd_target = {1'b1, `ONWD_BYTE_CFG2, `ONWD_MASK_TOS};
        end else if (loc >= `ONWD_LOC_UD_FIRST) begin
          onwd_target = {1'b1, `ONWD_BYTE_UD1 + ofs, `ONWD_MASK_HI};
        end
      end
    end
  endfunction

  reg  [3:0]  state;
  reg  [3:0]  lat_loc;
  reg  [1:0]  lat_bank;
  reg  [3:0]  lat_data;
  reg         lat_pe;
  reg         lat_used;
  reg  [3:0]  lat_byte;
  reg  [7:0]  lat_mask;
  reg  [7:0]  cfg1;
  reg  [7:0]  cfg2;
  reg  [7:0]  type_byte;
  reg  [7:0]  next_byte;
  reg  [3:0]  next_nibble;
  wire [12:0] dec;
  wire        accept;
  wire [7:0]  wr_data;
  wire        is_udata;
  wire [3:0]  ud_index;
  wire [7:0]  ud_rd;

  assign dec      = onwd_target(bank_in, nibble_location_in);
  // Commands arriving while a write is in flight are dropped
  assign accept   = cmd_valid_in && state == ST_IDLE &&
                    cmd_long_format_in &&
                    cmd_addr_in != `ONWD_GLOBAL_ADDR &&
                    cmd_addr_in == cfg2[3:0];
  assign wr_data  = {lat_data, lat_data} & lat_mask;
  assign is_udata = lat_byte >= `ONWD_BYTE_UD1;
  assign ud_index = lat_byte - `ONWD_BYTE_UD1;

  assign node_address_out           = cfg2[3:0];
  assign user_lock_out              = cfg2[7];
  assign test_output_select_out     = cfg2[5];
  assign filter_selection_out       = type_byte[7:6];
  assign device_id_select_out       = cfg1[7];
  assign auxiliary_config_field_out = cfg1[1:0];

  onwd_udata_mem #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_udata (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (state == ST_WRITE && lat_used && is_udata),
    .wr_addr_in  (ud_index[2:0]),
    .wr_mask_in  (lat_mask),
    .wr_data_in  (wr_data),
    .rd_en_in    (state == ST_READ),
    .rd_addr_in  (ud_index[2:0]),
    .rd_data_out (ud_rd)
  );

  // Contents of the addressed nibble after the write
  always @* begin
    next_byte = ud_rd;
    case (lat_byte)
      `ONWD_BYTE_CFG1: next_byte = cfg1;
      `ONWD_BYTE_CFG2: next_byte = cfg2;
      `ONWD_BYTE_TYPE: next_byte = type_byte;
      default:         next_byte = ud_rd;
    endcase
    next_nibble = (|lat_mask[7:4]) ? next_byte[7:4] : next_byte[3:0];
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state           <= ST_IDLE;
      lat_loc         <= 4'h0;
      lat_bank        <= 2'h0;
      lat_data        <= 4'h0;
      lat_pe          <= 1'b0;
      lat_used        <= 1'b0;
      lat_byte        <= 4'h0;
      lat_mask        <= 8'h00;
      cfg1            <= `ONWD_RST_CFG1;
      cfg2            <= `ONWD_RST_CFG2;
      type_byte       <= `ONWD_RST_TYPE;
      resp_valid_out  <= 1'b0;
      resp_data_out   <= 16'h0000;
      otp_program_out <= 1'b0;
      otp_byte_out    <= 4'h0;
      otp_mask_out    <= 8'h00;
      otp_data_out    <= 8'h00;
    end else begin
      resp_valid_out  <= 1'b0;
      otp_program_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            lat_loc  <= nibble_location_in;
            lat_bank <= bank_in;
            lat_data <= cmd_data_in;
            lat_pe   <= program_enable_in;
            lat_used <= dec[12];
            lat_byte <= dec[11:8];
            lat_mask <= dec[7:0];
            state    <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          // Mirror follows the data whatever program enable says
          if (lat_used) begin
            case (lat_byte)
              `ONWD_BYTE_CFG1:
                cfg1 <= (cfg1 & ~lat_mask) | wr_data;
              `ONWD_BYTE_CFG2:
                cfg2 <= (cfg2 & ~lat_mask) | wr_data;
              `ONWD_BYTE_TYPE:
                type_byte <= (type_byte & ~lat_mask) | wr_data;
              default: begin
              end
            endcase
          end
          if (lat_used && lat_pe) begin
            otp_program_out <= 1'b1;
            otp_byte_out    <= lat_byte;
            otp_mask_out    <= lat_mask;
            otp_data_out    <= wr_data;
          end
          state <= ST_READ;
        end
        ST_READ: begin
          state <= ST_RESP;
        end
        ST_RESP: begin
          resp_valid_out <= 1'b1;
          if (!lat_pe) begin
            resp_data_out <= {cfg2[3:0], `ONWD_RESP_ZERO,
                              `ONWD_RESP_ONES, cfg2[3:0]};
          end else if (!lat_used) begin
            resp_data_out <= {cfg2[3:0], lat_loc, `ONWD_RESP_MARK,
                              lat_bank, cfg2[3:0]};
          end else begin
            resp_data_out <= {cfg2[3:0], lat_loc, `ONWD_RESP_MARK,
                              lat_bank, next_nibble};
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // onwd_decoder

// ===== verification/onwd_decoder_assertions.sv
// Concurrent checks on the write-nibble decoder ports
module onwd_decoder_chk (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire        cmd_valid_in,
  input wire        cmd_long_format_in,
  input wire [3:0]  cmd_addr_in,
  input wire [3:0]  nibble_location_in,
  input wire [3:0]  cmd_data_in,
  input wire [1:0]  bank_in,
  input wire        program_enable_in,
  input wire        resp_valid_out,
  input wire [15:0] resp_data_out,
  input wire        otp_program_out,
  input wire [3:0]  otp_byte_out,
  input wire [7:0]  otp_mask_out,
  input wire [7:0]  otp_data_out,
  input wire [3:0]  node_address_out,
  input wire        user_lock_out,
  input wire        test_output_select_out,
  input wire [1:0]  filter_selection_out,
  input wire        device_id_select_out,
  input wire [1:0]  auxiliary_config_field_out
);
  reg  [1:0] busy;
  wire [3:0] loc = nibble_location_in;
  wire       taken = cmd_valid_in && cmd_long_format_in && busy == 2'h0 &&
                     cmd_addr_in != 4'h0 && cmd_addr_in == node_address_out;
  wire       taken_pe = taken && program_enable_in;
  wire       used = (bank_in == 2'h0 && (loc == 4'h7 || loc == 4'h8 ||
                     loc == 4'hA)) || (bank_in == 2'h1 && loc >= 4'h6 &&
                     loc <= 4'hE) || (bank_in == 2'h2 && loc >= 4'h7);
  // Commands in the three cycles after a taken one are dropped
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) busy <= 2'h0;
    else if (taken) busy <= 2'h3;
    else if (busy != 2'h0) busy <= busy - 2'h1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_cmd; taken; endsequence
  sequence s_answer; ##4 resp_valid_out; endsequence
  chk_resp_latency: assert property (s_cmd |-> s_answer)
    else $error("response not four cycles after command");
  chk_no_spurious: assert property (resp_valid_out |-> $past(taken, 4))
    else $error("response without a taken command");
  chk_pe0_format: assert property (s_cmd ##0 !program_enable_in |-> ##4
    resp_data_out == {node_address_out, 8'h0F, node_address_out})
    else $error("mirror-only response word wrong");
  chk_pe1_header: assert property (taken_pe |-> ##4
    resp_data_out[11:4] == {$past(loc, 4), 2'h3, $past(bank_in, 4)})
    else $error("program response header wrong");
  chk_otp_cause: assert property (otp_program_out |-> $past(taken_pe, 2))
    else $error("OTP pulse without enabled command");
  chk_unused_quiet: assert property (s_cmd ##0 !used |->
    ##2 !otp_program_out ##2 resp_data_out[3:0] == node_address_out)
    else $error("unused location programmed or answered wrong");
  chk_addr_write: assert property (s_cmd ##0 bank_in == 2'h1 &&
    loc == 4'h7 |-> ##2 node_address_out == $past(cmd_data_in, 2))
    else $error("node address not written");
  chk_mask_bits: assert property (otp_program_out |-> otp_mask_out != 8'h00
    && (otp_data_out & ~otp_mask_out) == 8'h00)
    else $error("OTP data outside mask");
  chk_mirror_hold: assert property (!$past(taken, 2) |->
    $stable(node_address_out)) else $error("node address moved unasked");
endmodule // onwd_decoder_chk
bind onwd_decoder onwd_decoder_chk i_onwd_decoder_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_long_format_in(cmd_long_format_in), .cmd_addr_in(cmd_addr_in),
  .nibble_location_in(nibble_location_in), .cmd_data_in(cmd_data_in),
  .bank_in(bank_in), .program_enable_in(program_enable_in),
  .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
  .otp_program_out(otp_program_out), .otp_byte_out(otp_byte_out),
  .otp_mask_out(otp_mask_out), .otp_data_out(otp_data_out),
  .node_address_out(node_address_out), .user_lock_out(user_lock_out),
  .test_output_select_out(test_output_select_out),
  .filter_selection_out(filter_selection_out),
  .device_id_select_out(device_id_select_out),
  .auxiliary_config_field_out(auxiliary_config_field_out));

// ===== verification/onwd_master_model.sv
// Bus master model issuing write-nibble commands
module onwd_master_model (
  input  wire       core_clk_in,
  output reg        cmd_valid_out,
  output wire       cmd_long_format_out,
  output wire [3:0] cmd_addr_out,
  output wire [3:0] nibble_location_out,
  output wire [3:0] cmd_data_out,
  output wire [1:0] bank_out,
  output wire       program_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [15:0] f = 16'h0000;
  integer    gap = 0;
  assign {cmd_long_format_out, cmd_addr_out, nibble_location_out,
          cmd_data_out, bank_out, program_enable_out} = f;
  initial cmd_valid_out = 1'b0;
  task automatic send(input [1:0] b, input [3:0] l, d, input p, lg,
                      input [3:0] a);
    repeat (gap) @(negedge core_clk_in);
    f = {lg, a, l, d, b, p};
    cmd_valid_out = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    // Fields are meaningless between commands, so never leave them stale
    f = ~f;
    // Worst case of four bits at one cycle each, on top of the turnaround
    gap = 8;
  endtask
endmodule // onwd_master_model

// ===== verification/tb_onwd_decoder.sv
// Self-checking bench for the write-nibble decoder
module tb_onwd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  wire        v, lf, pe, resp_valid_out, otp_program_out, lock, tos, device_id_select;
  wire [3:0]  ca, nl, cd, otp_byte_out, node;
  wire [1:0]  bk, filt, aux;
  wire [15:0] resp_data_out;
  wire [7:0]  otp_mask_out, otp_data_out;
  integer     n_fail = 0, total_checks = 0, otp_cnt = 0, cycles = 0;
  onwd_master_model i_onwd_master_model (.core_clk_in(core_clk_in),
    .cmd_valid_out(v), .cmd_long_format_out(lf), .cmd_addr_out(ca),
    .nibble_location_out(nl), .cmd_data_out(cd), .bank_out(bk),
    .program_enable_out(pe));
  onwd_decoder i_onwd_decoder (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .cmd_valid_in(v), .cmd_long_format_in(lf), .cmd_addr_in(ca),
    .nibble_location_in(nl), .cmd_data_in(cd), .bank_in(bk),
    .program_enable_in(pe), .resp_valid_out(resp_valid_out),
    .resp_data_out(resp_data_out), .otp_program_out(otp_program_out),
    .otp_byte_out(otp_byte_out), .otp_mask_out(otp_mask_out),
    .otp_data_out(otp_data_out), .node_address_out(node),
    .user_lock_out(lock),
    .test_output_select_out(tos), .filter_selection_out(filt),
    .device_id_select_out(device_id_select), .auxiliary_config_field_out(aux));
  initial forever #2 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) if (otp_program_out === 1'b1) otp_cnt++;
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic used(input [1:0] b, input [3:0] l);
    return (b == 2'h0 && (l == 4'h7 || l == 4'h8 || l == 4'hA)) ||
      (b == 2'h1 && l >= 4'h6 && l <= 4'hE) || (b == 2'h2 && l >= 4'h7);
  endfunction
  // One command; nib is the answered nibble, np the OTP pulses expected
  task automatic wr(input [1:0] b, input [3:0] l, d, input p, lg,
    input [3:0] a, input ok, input [3:0] nib, input integer np);
    integer n, p0;
    p0 = otp_cnt;
    i_onwd_master_model.send(b, l, d, p, lg, a);
    n = 0;
    while (resp_valid_out !== 1'b1 && n < 6) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("resp_valid", 16'(resp_valid_out), 16'(ok));
    if (ok) chk("resp_data", resp_data_out,
      p ? {a, l, 2'h3, b, nib} : {nib, 8'h0F, nib});
    chk("otp_pulses", 16'(otp_cnt - p0), 16'(np));
  endtask
  initial begin
    repeat (5) @(negedge core_clk_in);
    rst_in = 1'b0;
    chk("reset", 16'({node, lock, tos, filt, device_id_select, aux}), 16'h0080);
    chk("reset_resp", resp_data_out, 16'h0000);
    chk("reset_otp", {otp_byte_out, otp_mask_out, 4'h0}, 16'h0000);
    chk("reset_otp_data", 16'(otp_data_out), 16'h0000);
    wr(2'h1, 4'h7, 4'h5, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0, 0);
    wr(2'h1, 4'h7, 4'h5, 1'b0, 1'b0, 4'h1, 1'b0, 4'h0, 0);
    wr(2'h1, 4'h7, 4'h5, 1'b0, 1'b1, 4'h2, 1'b0, 4'h0, 0);
    $display("test ignored commands done");
    wr(2'h1, 4'h7, 4'h5, 1'b0, 1'b1, 4'h1, 1'b1, 4'h5, 0);
    wr(2'h1, 4'h9, 4'h6, 1'b0, 1'b1, 4'h5, 1'b1, 4'h5, 0);
    wr(2'h0, 4'h7, 4'hF, 1'b1, 1'b1, 4'h5, 1'b1, 4'h8, 1);
    chk("lock_otp", {otp_byte_out, otp_mask_out, 4'h0}, 16'h1800);
    chk("lock_data", 16'(otp_data_out), 16'h0080);
    wr(2'h0, 4'h8, 4'hF, 1'b1, 1'b1, 4'h5, 1'b1, 4'hC, 1);
    wr(2'h0, 4'hA, 4'hF, 1'b1, 1'b1, 4'h5, 1'b1, 4'h8, 1);
    wr(2'h1, 4'h6, 4'hF, 1'b1, 1'b1, 4'h5, 1'b1, 4'h3, 1);
    wr(2'h2, 4'h7, 4'hF, 1'b1, 1'b1, 4'h5, 1'b1, 4'hA, 1);
    chk("tos_otp", {otp_byte_out, otp_mask_out, 4'h0}, 16'h1200);
    chk("tos_data", 16'(otp_data_out), 16'h0020);
    chk("fields", 16'({lock, tos, filt, device_id_select, aux, node}), 16'h07F5);
    $display("test config fields done");
    for (int l = 8; l <= 15; l++) begin
      if (l < 15) begin
        wr(2'h1, 4'(l), 4'(l ^ 3), 1'b1, 1'b1, 4'h5, 1'b1, 4'(l ^ 3), 1);
        chk("lo_byte", {otp_byte_out, otp_mask_out, 4'h0},
          {4'(l - 5), 8'h0F, 4'h0});
        chk("lo_data", 16'(otp_data_out), {12'h000, 4'(l ^ 3)});
      end
      wr(2'h2, 4'(l), 4'(l ^ 9), 1'b1, 1'b1, 4'h5, 1'b1, 4'(l ^ 9), 1);
      chk("hi_byte", {otp_byte_out, otp_mask_out, 4'h0},
        {4'(l - 5), 8'hF0, 4'h0});
      chk("hi_data", 16'(otp_data_out), {8'h00, 4'(l ^ 9), 4'h0});
    end
    $display("test user bytes done");
    for (int b = 0; b < 4; b++)
      for (int l = 0; l < 16; l++)
        if (!used(2'(b), 4'(l)))
          wr(2'(b), 4'(l), 4'hF, 1'b1, 1'b1, 4'h5, 1'b1, 4'h5, 0);
    // Mirror-only write to an unused location still answers the address
    wr(2'h3, 4'h0, 4'hF, 1'b0, 1'b1, 4'h5, 1'b1, 4'h5, 0);
    chk("kept", 16'({lock, tos, filt, device_id_select, aux, node}), 16'h07F5);
    $display("test unused locations done");
    report_and_stop();
  end
endmodule // tb_onwd_decoder
